// file: pkg/coproc_pkg.sv
package coproc_pkg;
    // ==================== Opcodes and fields ====================
    localparam logic [3:0] OP_SERIAL = 4'h3;
    localparam logic [3:0] OP_PREG_WR = 4'h1;
    localparam logic [3:0] OP_PREG_RD = 4'h2;
    localparam logic [3:0] OP_MEASURE = 4'h5;
    localparam logic [3:0] OP_CONTROL = 4'h9;
    localparam logic [3:0] OP_WAIT = 4'h4;
    localparam logic [3:0] OP_TEMP = 4'ha;
    localparam logic [2:0] SUB_HALT = 3'h0;
    localparam logic [2:0] SUB_WAKE = 3'h1;
    localparam logic [2:0] SUB_SLEEP = 3'h2;
    localparam int OP_HI = 31;
    localparam int OP_LO = 28;
    localparam int SUB_HI = 27;
    localparam int SUB_LO = 25;
    localparam int NUM_PERIODS = 5;
    localparam int NUM_TARGETS = 8;
    localparam int RD_SPAN_MAX = 16;
    localparam int WR_SPAN_MAX = 8;
    localparam int PADS_PER_CONV = 10;
    localparam logic [9:0] REGION_LIMIT = 10'h3ff;
    localparam logic [15:0] WAIT_DONE = 16'h0000;
    // ==================== Register map ====================
    localparam logic [7:0] A_PERIOD0 = 8'h00;
    localparam logic [7:0] A_TARGET0 = 8'h08;
    localparam logic [7:0] A_CTRL = 8'h10;
    localparam logic [7:0] A_PC_INIT = 8'h11;
    localparam logic [7:0] A_STATUS = 8'h12;
    localparam logic [7:0] A_REGS = 8'h13;
    localparam logic [31:0] PERIOD_RESET = 32'h000000c8;
    localparam int CTRL_TIMER_EN = 0;
    localparam int CTRL_IRQ_EN = 1;
    localparam int CTRL_WAKE_EN = 2;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [9:0]  addr;
        logic [31:0] wdata;
        logic [31:0] mask;
        logic        wr;
        logic        rd;
    } preg_req_t;
endpackage

// file: logic/coproc_ctrl.sv
//Contract
//[RULE_01] Halt stops the core, powers it down and starts the sleep timer.
//[RULE_02] Wake raises an interrupt; in deep sleep with wake enabled it wakes system.
//[RULE_03] Outside deep sleep the wake interrupt needs the interrupt enable bit.
//[RULE_04] Sleep selects one of five period registers, indexes 0 to 4.
//[RULE_05] Period register zero is used until a sleep instruction selects otherwise.
//[RULE_06] Wait holds off sleep for its cycle operand.
//[RULE_07] Temperature starts a conversion, waits its delay, writes R0..R3.
//[RULE_08] Converter select bit: 0 first converter, 1 second.
//[RULE_09] Converter enables pad number mux field minus one, field 1 to 10.
//[RULE_10] Serial-bus opcode 3; direction bit 1 writes, 0 reads.
//[RULE_11] Select field picks one of eight target addresses; sub-address is register.
//[RULE_12] Data byte is sent on write, ignored on read; high/low form mask. No mask is sent here; bus_data is the whole byte.
//[RULE_13] Serial controller samples data on falling serial clock edge.
//[RULE_14] Register read puts bits high..low of peripheral register into R0.
//[RULE_15] Spans above sixteen return sixteen bits starting at low.
//[RULE_16] Peripheral addresses are 10-bit words based at control block.
//[RULE_17] Accesses reach only the four always-on register regions.
//[RULE_18] Register write puts 8-bit immediate into high..low, zero above eighth bit.
//[RULE_19] Timer counts ticks after halt; on expiry start at initial PC.
//[RULE_20] Software sets timer enable to run periodically, clears it to stop.
//[RULE_21] After reset the program waits period register zero before starting.
//[RULE_22] Serial-bus read stores the received byte into R0.
//[RULE_23] Wait counts core clock cycles down to zero before proceeding.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module coproc_ctrl
    import coproc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Instruction issue
    input  wire logic [31:0] instr,
    input  wire logic        instr_valid,
    output logic             instr_done,
    output logic             core_run,
    output logic      [12:0] core_pc_start,
    // System and slow clock
    input  wire logic        slow_tick,
    input  wire logic        deep_sleep,
    output logic             aon_irq,
    output logic             sys_wake,
    // Analog converters
    output logic             conv_start,
    output logic             conv_sel,
    output logic      [3:0]  pad_enable_idx,
    output logic             temp_start,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_result,
    // Serial-bus controller
    output logic             bus_start,
    output logic             bus_write,
    output logic      [7:0]  bus_target,
    output logic      [7:0]  bus_subaddr,
    output logic      [7:0]  bus_data,
    input  wire logic        bus_done,
    input  wire logic [7:0]  bus_rx_byte,
    // Peripheral register access
    output preg_req_t        preg,
    input  wire logic        preg_ack,
    input  wire logic [31:0] preg_rdata
);
    typedef enum {S_SLEEP, S_RUN, S_WAITING, S_CONV, S_BUS, S_PREG} state_t;
    state_t state;

    // ==================== Storage ====================
    logic [31:0] period [NUM_PERIODS];
    logic [7:0]  target [NUM_TARGETS];
    logic [2:0]  ctrl;
    logic [12:0] pc_init;
    logic [2:0]  period_sel;
    logic [31:0] timer;
    logic [15:0] wait_cnt;
    logic [15:0] gpr [4];
    logic [1:0]  dst;
    logic        rd_to_r0;
    logic        pending_rd;
    logic        conv_seen;

    // ==================== Decode ====================
    wire [3:0]  op      = instr[OP_HI:OP_LO];
    wire [2:0]  sub     = instr[SUB_HI:SUB_LO];
    wire [4:0]  hi_bit  = instr[27:23];
    wire [4:0]  lo_bit  = instr[22:18];
    wire [9:0]  p_addr  = instr[9:0];
    wire [4:0]  span_m1 = hi_bit - lo_bit;
    wire        issue   = instr_valid && state == S_RUN;
    wire        in_region = p_addr <= REGION_LIMIT;  // RULE_17

    function automatic logic [31:0] field_mask(input logic [4:0] lo, input logic [4:0] w);
        field_mask = ((32'h1 << w) - 32'h1) << lo;
    endfunction

    wire [4:0]  rd_w    = (span_m1 >= 5'(RD_SPAN_MAX)) ? 5'(RD_SPAN_MAX) : span_m1 + 5'h1;  // RULE_15
    wire [4:0]  wr_w    = span_m1 + 5'h1;
    wire [31:0] wr_val  = 32'(instr[17:10]) << lo_bit;  // RULE_18
    wire [31:0] rd_val  = (preg_rdata & field_mask(lo_bit, rd_w)) >> lo_bit;  // RULE_14
    wire [2:0]  sel_p   = (instr[2:0] < 3'(NUM_PERIODS)) ? instr[2:0] : 3'h0;  // RULE_04
    wire        timer_hit = slow_tick && timer + 32'h1 >= period[period_sel];  // RULE_19

    // ==================== Register port ====================
    wire [31:0] rd_mux =
        (reg_addr < A_TARGET0) ? ((reg_addr < 8'(NUM_PERIODS)) ? period[reg_addr[2:0]] : 32'h0) :
        (reg_addr < A_CTRL) ? 32'(target[reg_addr[2:0]]) :
        (reg_addr == A_CTRL) ? 32'(ctrl) :
        (reg_addr == A_PC_INIT) ? 32'(pc_init) :
        (reg_addr == A_STATUS) ? {25'h0, period_sel, 1'b0, 3'(state)} :
        (reg_addr >= A_REGS && reg_addr < A_REGS + 8'h4) ? 32'(gpr[reg_addr[1:0] + 2'h1]) : 32'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h0;
            ctrl      <= 3'h0;
            pc_init   <= 13'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
            if (reg_wr && reg_addr == A_CTRL)
                ctrl <= reg_wdata[2:0];  // RULE_20
            if (reg_wr && reg_addr == A_PC_INIT)
                pc_init <= reg_wdata[12:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PERIODS; g++) begin : g_per
            always_ff @(posedge clk) begin
                if (rst)
                    period[g] <= PERIOD_RESET;
                else if (reg_wr && reg_addr == A_PERIOD0 + 8'(g))
                    period[g] <= reg_wdata;
            end
        end
        for (g = 0; g < NUM_TARGETS; g++) begin : g_tgt
            always_ff @(posedge clk) begin
                if (rst)
                    target[g] <= 8'h0;
                else if (reg_wr && reg_addr == A_TARGET0 + 8'(g))
                    target[g] <= reg_wdata[7:0];
            end
        end
    endgenerate

    // ==================== Sequencer ====================
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= S_SLEEP;
            period_sel <= 3'h0;  // RULE_05
            timer <= 32'h0;
            wait_cnt <= 16'h0;
            core_run <= 1'b0;
            core_pc_start <= 13'h0;
            instr_done <= 1'b0;
            aon_irq <= 1'b0;
            sys_wake <= 1'b0;
            conv_start <= 1'b0;
            conv_sel <= 1'b0;
            pad_enable_idx <= 4'h0;
            temp_start <= 1'b0;
            bus_start <= 1'b0;
            bus_write <= 1'b0;
            bus_target <= 8'h0;
            bus_subaddr <= 8'h0;
            bus_data <= 8'h0;
            preg <= '0;
            dst <= 2'h0;
            rd_to_r0 <= 1'b0;
            pending_rd <= 1'b0;
            conv_seen <= 1'b0;
            for (int i = 0; i < 4; i++) gpr[i] <= 16'h0;
        end else begin
            instr_done <= 1'b0;
            aon_irq <= 1'b0;
            sys_wake <= 1'b0;
            conv_start <= 1'b0;
            temp_start <= 1'b0;
            bus_start <= 1'b0;
            preg.wr <= 1'b0;
            preg.rd <= 1'b0;
            case (state)
                S_SLEEP: begin
                    if (ctrl[CTRL_TIMER_EN] && slow_tick)
                        timer <= timer + 32'h1;  // RULE_21
                    if (ctrl[CTRL_TIMER_EN] && timer_hit) begin
                        timer <= 32'h0;
                        core_run <= 1'b1;
                        core_pc_start <= pc_init;  // RULE_19
                        state <= S_RUN;
                    end
                end
                S_RUN: if (issue) begin
                    if (op == OP_CONTROL && sub == SUB_HALT) begin
                        core_run <= 1'b0;  // RULE_01
                        timer <= 32'h0;
                        state <= S_SLEEP;
                    end else if (op == OP_CONTROL && sub == SUB_WAKE) begin
                        sys_wake <= deep_sleep && ctrl[CTRL_WAKE_EN];  // RULE_02
                        aon_irq <= deep_sleep || ctrl[CTRL_IRQ_EN];  // RULE_03
                        instr_done <= 1'b1;
                    end else if (op == OP_CONTROL && sub == SUB_SLEEP) begin
                        period_sel <= sel_p;  // RULE_04
                        instr_done <= 1'b1;
                    end else if (op == OP_WAIT) begin
                        wait_cnt <= instr[15:0];  // RULE_06
                        state <= S_WAITING;
                    end else if (op == OP_TEMP) begin
                        temp_start <= 1'b1;  // RULE_07
                        dst <= instr[1:0];
                        wait_cnt <= instr[17:2];
                        state <= S_CONV;
                    end else if (op == OP_MEASURE) begin
                        conv_start <= 1'b1;
                        conv_sel <= instr[6];  // RULE_08
                        pad_enable_idx <= instr[5:2] - 4'h1;  // RULE_09
                        dst <= instr[1:0];
                        wait_cnt <= WAIT_DONE;
                        state <= S_CONV;
                    end else if (op == OP_SERIAL) begin
                        bus_start <= 1'b1;  // RULE_13
                        bus_write <= instr[27];  // RULE_10
                        bus_target <= target[instr[24:22]];  // RULE_11
                        bus_subaddr <= instr[7:0];
                        bus_data <= instr[27] ? instr[15:8] : 8'h0;  // RULE_12
                        rd_to_r0 <= !instr[27];
                        state <= S_BUS;
                    end else if ((op == OP_PREG_RD || op == OP_PREG_WR) && in_region) begin
                        preg.addr <= p_addr;  // RULE_16
                        preg.wr <= op == OP_PREG_WR;
                        preg.rd <= op == OP_PREG_RD;
                        preg.wdata <= wr_val & field_mask(lo_bit, wr_w);  // RULE_18
                        preg.mask <= field_mask(lo_bit, wr_w);
                        pending_rd <= op == OP_PREG_RD;
                        state <= S_PREG;
                    end else
                        instr_done <= 1'b1;
                end
                S_WAITING: begin
                    if (wait_cnt == WAIT_DONE) begin
                        instr_done <= 1'b1;  // RULE_23
                        state <= S_RUN;
                    end else
                        wait_cnt <= wait_cnt - 16'h1;
                end
                S_CONV: begin
                    // Result may land while the delay still runs
                    if (conv_done) begin
                        gpr[dst] <= conv_result;  // RULE_07
                        conv_seen <= 1'b1;
                    end
                    if (wait_cnt != WAIT_DONE)
                        wait_cnt <= wait_cnt - 16'h1;
                    else if (conv_done || conv_seen) begin
                        conv_seen <= 1'b0;
                        instr_done <= 1'b1;
                        state <= S_RUN;
                    end
                end
                S_BUS: if (bus_done) begin
                    if (rd_to_r0)
                        gpr[0] <= 16'(bus_rx_byte);  // RULE_22
                    instr_done <= 1'b1;
                    state <= S_RUN;
                end
                S_PREG: if (preg_ack) begin
                    if (pending_rd)
                        gpr[0] <= rd_val[15:0];  // RULE_14
                    instr_done <= 1'b1;
                    state <= S_RUN;
                end
                default: state <= S_SLEEP;
            endcase
        end
    end

    // ==================== Checks ====================
    a_halt_stops: assert property (@(posedge clk) disable iff (rst)
        issue && op == OP_CONTROL && sub == SUB_HALT |=> !core_run && state == S_SLEEP)  // RULE_01
        else $error("halt did not stop core");
    a_wake_gate: assert property (@(posedge clk) disable iff (rst)
        issue && op == OP_CONTROL && sub == SUB_WAKE && !deep_sleep && !ctrl[CTRL_IRQ_EN] |=> !aon_irq)  // RULE_03
        else $error("wake irq without enable");
    a_wake_sys: assert property (@(posedge clk) disable iff (rst)
        sys_wake |-> aon_irq)  // RULE_02
        else $error("system wake without irq");
    a_sleep_sel: assert property (@(posedge clk) disable iff (rst)
        period_sel < 3'(NUM_PERIODS))  // RULE_04
        else $error("period select out of range");
    a_wait_hold: assert property (@(posedge clk) disable iff (rst)
        issue && op == OP_WAIT && instr[15:0] == 16'h0003 |=> !instr_done [*4] ##1 instr_done)  // RULE_06
        else $error("wait length wrong");
    a_start_pc: assert property (@(posedge clk) disable iff (rst)
        $rose(core_run) |-> core_pc_start == $past(pc_init))  // RULE_19
        else $error("start pc wrong");
    a_bus_dir: assert property (@(posedge clk) disable iff (rst)
        bus_start && !bus_write |-> bus_data == 8'h0)  // RULE_12
        else $error("read carries data");
    a_preg_span: assert property (@(posedge clk) disable iff (rst)
        state == S_PREG && preg_ack && pending_rd |=> gpr[0] == $past(rd_val[15:0]))  // RULE_15
        else $error("read field wrong");
    a_no_sleep_run: assert property (@(posedge clk) disable iff (rst)
        state == S_SLEEP && !ctrl[CTRL_TIMER_EN] |=> state == S_SLEEP)  // RULE_21
        else $error("started without timer");
endmodule
`default_nettype wire

// file: test/coproc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module coproc_partner
    import coproc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Converters
    input  wire logic        conv_start,
    input  wire logic        temp_start,
    input  wire logic        conv_sel,
    input  wire logic [3:0]  pad_enable_idx,
    output logic             conv_done,
    output logic      [15:0] conv_result,
    // Serial bus
    input  wire logic        bus_start,
    input  wire logic        bus_write,
    input  wire logic [7:0]  bus_target,
    input  wire logic [7:0]  bus_subaddr,
    input  wire logic [7:0]  bus_data,
    output logic             bus_done,
    output logic      [7:0]  bus_rx_byte,
    // Peripheral registers
    input  wire preg_req_t   preg,
    output logic             preg_ack,
    output logic      [31:0] preg_rdata,
    // Last write seen
    output logic      [31:0] cap
);
    // ==================== Answer engine ====================
    logic [1:0]  kind;
    logic [2:0]  cnt;
    logic        slow;
    logic [31:0] val;
    logic [31:0] word;
    wire         go = conv_start | temp_start | bus_start | preg.wr | preg.rd;

    // Answers alternate between fast and slow; idle data lines keep toggling
    always_ff @(posedge clk) begin
        conv_done <= 1'b0;
        bus_done <= 1'b0;
        preg_ack <= 1'b0;
        conv_result <= ~conv_result;
        bus_rx_byte <= ~bus_rx_byte;
        preg_rdata <= ~preg_rdata;
        if (rst) begin
            kind <= 2'd0;
            slow <= 1'b0;
            cap <= 32'h0;
            word <= 32'h9abcdef1;
            conv_result <= 16'h0;
            bus_rx_byte <= 8'h0;
            preg_rdata <= 32'h0;
        end else if (kind == 2'd0) begin
            if (go) begin
                cnt <= slow ? 3'd5 : 3'd1;
                slow <= ~slow;
            end
            if (conv_start | temp_start) begin
                kind <= 2'd1;
                val <= temp_start ? 32'h0a5a : {27'h0, conv_sel, pad_enable_idx};
            end else if (bus_start) begin
                kind <= 2'd2;
                val <= {24'h0, bus_target ^ bus_subaddr};
                if (bus_write) begin
                    cap <= {bus_target, bus_subaddr, bus_data, 8'h00};
                end
            end else if (preg.wr | preg.rd) begin
                kind <= 2'd3;
                val <= word;
                if (preg.wr) begin
                    cap <= {22'h0, preg.addr};
                    word <= (word & ~preg.mask) | (preg.wdata & preg.mask);
                end
            end
        end else if (cnt != 3'd0) begin
            cnt <= cnt - 3'd1;
        end else begin
            kind <= 2'd0;
            conv_done <= (kind == 2'd1);
            bus_done <= (kind == 2'd2);
            preg_ack <= (kind == 2'd3);
            if (kind == 2'd1) conv_result <= val[15:0];
            if (kind == 2'd2) bus_rx_byte <= val[7:0];
            if (kind == 2'd3) preg_rdata <= val;
        end
    end
endmodule
`default_nettype wire

// file: test/coproc_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module coproc_ctrl_tb_top
    import coproc_pkg::*;
;
    // ==================== Signals ====================
    typedef struct packed {logic [31:0] i; logic [7:0] a; logic [31:0] e;} row_t;
    logic        clk, rst, reg_wr, reg_rd, instr_valid, slow_tick, deep_sleep;
    logic        instr_done, core_run, aon_irq, sys_wake, conv_start, conv_sel, temp_start, conv_done;
    logic        bus_start, bus_write, bus_done, preg_ack;
    logic [3:0]  pad_enable_idx;
    logic [7:0]  reg_addr, bus_target, bus_subaddr, bus_data, bus_rx_byte;
    logic [12:0] core_pc_start;
    logic [15:0] conv_result;
    logic [31:0] reg_wdata, reg_rdata, instr, preg_rdata, cap, d;
    preg_req_t   preg;
    int          errors, compares, n, irq_n, wake_n, irq0, wake0;
    row_t        rows [9];
    logic [4:0]  wk [4];

    coproc_ctrl dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr, .instr_valid,
        .instr_done, .core_run, .core_pc_start, .slow_tick, .deep_sleep, .aon_irq, .sys_wake, .conv_start,
        .conv_sel, .pad_enable_idx, .temp_start, .conv_done, .conv_result, .bus_start, .bus_write,
        .bus_target, .bus_subaddr, .bus_data, .bus_done, .bus_rx_byte, .preg, .preg_ack, .preg_rdata);
    coproc_partner far (.clk, .rst, .conv_start, .temp_start, .conv_sel, .pad_enable_idx, .conv_done,
        .conv_result, .bus_start, .bus_write, .bus_target, .bus_subaddr, .bus_data, .bus_done,
        .bus_rx_byte, .preg, .preg_ack, .preg_rdata, .cap);

    // ==================== Clock, ticks, pulse counts ====================
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        slow_tick <= rst ? 1'b0 : ~slow_tick;
        if (aon_irq) irq_n++;
        if (sys_wake) wake_n++;
    end

    // ==================== Tasks ====================
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic issue(input logic [31:0] v);
        @(posedge clk);
        instr <= v;
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
    endtask
    task automatic ex(input logic [31:0] v);
        issue(v);
        n = 0;
        #1;
        while (instr_done !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 3000) chk("instr_done", 1, 0);
    endtask
    task automatic run_wait(input int lim);
        n = 0;
        while (core_run !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==================== Watchdog ====================
    initial begin
        #200000;
        errors++;
        give_verdict();
    end

    // ==================== Sequence ====================
    initial begin
        rows = '{'{{OP_TEMP, 10'h0, 16'd3, 2'd1}, 8'h14, 32'h0a5a},
                 '{{OP_MEASURE, 21'h0, 1'b0, 4'd1, 2'd2}, 8'h15, 32'h00},
                 '{{OP_MEASURE, 21'h0, 1'b1, 4'd10, 2'd3}, 8'h16, 32'h19},
                 '{{OP_SERIAL, 3'b000, 3'd5, 6'h38, 8'haa, 8'h34}, 8'h13, 32'h76},
                 '{{OP_SERIAL, 3'b100, 3'd5, 6'h38, 8'h5a, 8'h12}, 8'hff, 32'h42125a00},
                 '{{OP_PREG_RD, 5'd11, 5'd4, 8'h0, 10'h3ff}, 8'h13, 32'hef},
                 '{{OP_PREG_RD, 5'd31, 5'd4, 8'h0, 10'h3ff}, 8'h13, 32'hcdef},
                 '{{OP_PREG_WR, 5'd15, 5'd4, 8'ha5, 10'h005}, 8'hff, 32'h005},
                 '{{OP_PREG_RD, 5'd15, 5'd0, 8'h0, 10'h005}, 8'h13, 32'h0a51}};
        wk = '{5'b00110, 5'b00000, 5'b10010, 5'b11011};
        {rst, reg_wr, reg_rd, instr_valid, deep_sleep} = 5'b10000;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        instr = 32'h0;
        errors = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(A_PERIOD0);
        chk("period0", PERIOD_RESET, d);
        rd(A_STATUS);
        chk("status", 32'h0, d);
        rd(8'h40);
        chk("unmapped", 32'h0, d);
        wr(A_TARGET0 + 8'h5, 32'h42);
        wr(A_PC_INIT, 32'h123);
        wr(A_PERIOD0 + 8'h3, 32'h4);
        wr(A_CTRL, 32'h3);
        run_wait(1000);
        chk("first start", 1, 32'(n > 380 && n < 420));
        chk("start pc", 32'h123, 32'(core_pc_start));
        foreach (rows[k]) begin
            ex(rows[k].i);
            if (rows[k].a == 8'hff) d = cap;
            else rd(rows[k].a);
            chk("row result", rows[k].e, d);
        end
        ex({OP_WAIT, 12'h0, 16'd5});
        chk("wait cycles", 32'd6, 32'(n));
        for (int k = 0; k < 4; k++) begin
            deep_sleep <= wk[k][4];
            wr(A_CTRL, {29'h0, wk[k][3], wk[k][2], 1'b1});
            irq0 = irq_n;
            wake0 = wake_n;
            ex({OP_CONTROL, SUB_WAKE, 25'h0});
            repeat (3) @(posedge clk);
            chk("irq count", 32'(wk[k][1]), 32'(irq_n - irq0));
            chk("wake count", 32'(wk[k][0]), 32'(wake_n - wake0));
        end
        deep_sleep <= 1'b0;
        wr(A_PC_INIT, 32'h456);
        ex({OP_CONTROL, SUB_SLEEP, 22'h0, 3'd3});
        rd(A_STATUS);
        chk("period select", 32'h31, d);
        issue({OP_CONTROL, SUB_HALT, 25'h0});
        repeat (2) @(posedge clk);
        #1 chk("halted", 32'h0, 32'(core_run));
        run_wait(100);
        chk("restart", 1, 32'(n >= 3 && n < 20));
        chk("restart pc", 32'h456, 32'(core_pc_start));
        give_verdict();
    end
endmodule
`default_nettype wire
